// ===== src/serdes_dl_consts.svh
// Register offsets, field positions, reset values and counts of the channel datapath
`ifndef SERDES_DL_CONSTS_SVH
`define SERDES_DL_CONSTS_SVH

`define REG_CTRL      8'h00
`define REG_STAT      8'h04
`define REG_RXWORDS   8'h08

`define CTRL_MODE_LO  0
`define CTRL_MODE_HI  1
`define CTRL_DOUBLE   2
`define CTRL_ENC      3
`define CTRL_RATE3G   4
`define CTRL_TXEN     5
`define CTRL_RXEN     6
`define CTRL_W        7
`define CTRL_RST      7'h60

`define STAT_CFGERR   0
`define STAT_OVERRUN  1
`define STAT_PLLFB    2
`define STAT_SLIP_LO  4

`define SYM_W         5'h0a
`define SYM_W_ENC     5'h08
`define OS_LAST       3'h4
`define OS_MID        3'h2
`define FIFO_DEPTH    4
`define WORD_W        20

`endif

// ===== src/serdes_dl_pkg.sv
// Types shared by the channel datapath
package serdes_dl_pkg;
	typedef enum logic [1:0] {
		MODE_SDI    = 2'b00,
		MODE_DETLAT = 2'b01,
		MODE_CONV   = 2'b11
	} mode_e;
	typedef logic [19:0] word_t;
endpackage

// ===== src/serdes_fifo.sv
// Phase compensation FIFO with valid and ready on both sides
`timescale 1ns/100ps
`default_nettype none
module serdes_fifo #(
	parameter int W = 20,
	parameter int D = 4
) (
	// Clock and reset
	input  wire logic         clk,
	input  wire logic         rst_b,
	// Filling side
	input  wire logic         in_valid,
	output logic              in_ready,
	input  wire logic [W-1:0] in_data,
	// Draining side
	output logic              out_valid,
	input  wire logic         out_ready,
	output logic [W-1:0]      out_data
);
	localparam int AW = $clog2(D);

	logic [W-1:0] mem [D];
	logic [AW-1:0] wp;
	logic [AW-1:0] rp;
	logic [AW:0]   cnt;
	logic          push;
	logic          pop;

	assign in_ready  = (cnt != (AW+1)'(D));
	assign out_valid = (cnt != '0);
	assign push      = in_valid & in_ready;
	assign pop       = out_valid & out_ready;
	assign out_data  = mem[rp];

	always_ff @(posedge clk) begin
		if (push) begin
			mem[wp] <= in_data;
		end
	end

	// Each word is stored once and read once: nothing lost or repeated
	always_ff @(posedge clk or negedge rst_b) begin
		if (!rst_b) begin
			wp  <= '0;
			rp  <= '0;
			cnt <= '0;
		end else begin
			if (push) begin
				wp <= (wp == AW'(D-1)) ? '0 : wp + 1'b1;
			end
			if (pop) begin
				rp <= (rp == AW'(D-1)) ? '0 : rp + 1'b1;
			end
			cnt <= cnt + (AW+1)'(push) - (AW+1)'(pop);
		end
	end
endmodule
`default_nettype wire

// ===== src/serdes_sdi_detlat_datapath.sv
// Fabric-side serial channel datapath: video, converter and fixed-latency modes
//
// Functional notes
// - 10-bit video TX: FIFO then 10:1 serializer
// - 20-bit video TX adds byte serializer
// - Video TX serializes only, no coding
// - 10-bit video RX: deserializer, bit-slip, FIFO
// - 20-bit video RX adds byte deserializer
// - HD takes 10/20 bits, 3G only 20
// - Converter mode oversamples each bit five times
// - Fixed-latency mode uses register-mode FIFOs
// - Register-mode FIFO adds exactly one cycle
// - Single width: 8 coded or 10 raw
// - Double width: 16 coded or 20 raw
// - Fixed-latency mode enables PLL feedback path
`timescale 1ns/100ps
`default_nettype none
`include "serdes_dl_consts.svh"
module serdes_sdi_detlat_datapath (
	// Clock and reset
	input  wire logic                SYS_CLK,
	input  wire logic                RST_B,
	// AHB-Lite slave
	input  wire logic                HSEL,
	input  wire logic [31:0]         HADDR,
	input  wire logic [1:0]          HTRANS,
	input  wire logic                HWRITE,
	input  wire logic [2:0]          HSIZE,
	input  wire logic [31:0]         HWDATA,
	input  wire logic                HREADY,
	output logic [31:0]              HRDATA,
	output logic                     HREADYOUT,
	output logic                     HRESP,
	// Transmit fabric side
	input  wire serdes_dl_pkg::word_t TX_DATA,
	input  wire logic                TX_VALID,
	output logic                     TX_READY,
	// Receive fabric side
	output serdes_dl_pkg::word_t     RX_DATA,
	output logic                     RX_VALID,
	input  wire logic                RX_READY,
	input  wire logic                RX_SLIP,
	// Line side
	output logic                     TX_SER,
	input  wire logic                RX_SER,
	// Channel PLL and coder controls
	output logic                     PLL_FB_EN,
	output logic                     ENC_EN
);
	import serdes_dl_pkg::*;

	// ****************************************
	// Register bus
	// ****************************************
	logic [`CTRL_W-1:0] ctrl;
	logic               ap_wr;
	logic [7:0]         ap_addr;
	logic               ap_go;
	logic               overrun;
	logic [3:0]         slip_cnt;
	logic [15:0]        rx_words;
	logic               cfg_err;
	logic [31:0]        rd_val;
	logic               clr_overrun;

	assign ap_go     = HSEL & HREADY & HTRANS[1];
	assign HREADYOUT = 1'b1;
	assign HRESP     = 1'b0;

	always_ff @(posedge SYS_CLK or negedge RST_B) begin
		if (!RST_B) begin
			ap_wr   <= 1'b0;
			ap_addr <= 8'h00;
		end else begin
			ap_wr   <= ap_go & HWRITE;
			ap_addr <= HADDR[7:0];
		end
	end

	always_ff @(posedge SYS_CLK or negedge RST_B) begin
		if (!RST_B) begin
			ctrl <= `CTRL_RST;
		end else if (ap_wr && ap_addr == `REG_CTRL) begin
			ctrl <= HWDATA[`CTRL_W-1:0];
		end
	end

	assign clr_overrun = ap_wr && ap_addr == `REG_STAT && HWDATA[`STAT_OVERRUN];

	always_comb begin
		rd_val = 32'h0000_0000;
		unique case (HADDR[7:0])
			`REG_CTRL: begin
				rd_val[`CTRL_W-1:0] = ctrl;
			end
			`REG_STAT: begin
				rd_val[`STAT_CFGERR]              = cfg_err;
				rd_val[`STAT_OVERRUN]             = overrun;
				rd_val[`STAT_PLLFB]               = PLL_FB_EN;
				rd_val[`STAT_SLIP_LO+3:`STAT_SLIP_LO] = slip_cnt;
			end
			`REG_RXWORDS: begin
				rd_val[15:0] = rx_words;
			end
			default: begin
				rd_val = 32'h0000_0000;
			end
		endcase
	end

	// Read data is caught in the address phase so the slave never waits
	always_ff @(posedge SYS_CLK or negedge RST_B) begin
		if (!RST_B) begin
			HRDATA <= 32'h0000_0000;
		end else if (ap_go && !HWRITE) begin
			HRDATA <= rd_val;
		end
	end

	// ****************************************
	// Mode decode
	// ****************************************
	logic       sdi;
	logic       detlat;
	logic       conv;
	logic       dw;
	logic       tx_en;
	logic       rx_en;
	logic [4:0] sym;
	logic [4:0] tot;

	assign sdi    = ctrl[`CTRL_MODE_HI:`CTRL_MODE_LO] == MODE_SDI;
	assign detlat = ctrl[`CTRL_MODE_HI:`CTRL_MODE_LO] == MODE_DETLAT;
	assign conv   = ctrl[`CTRL_MODE_HI:`CTRL_MODE_LO] == MODE_CONV;
	assign tx_en  = ctrl[`CTRL_TXEN];
	assign rx_en  = ctrl[`CTRL_RXEN];

	// 3G video forces the 20-bit path; HD follows the width bit
	assign dw = (detlat & ctrl[`CTRL_DOUBLE]) | (sdi & (ctrl[`CTRL_DOUBLE] | ctrl[`CTRL_RATE3G]));

	// Coding is only legal with fixed latency; video and converter stay raw
	assign ENC_EN = detlat & ctrl[`CTRL_ENC];
	assign sym    = ENC_EN ? `SYM_W_ENC : `SYM_W;
	assign tot    = dw ? 5'(sym << 1) : sym;

	assign cfg_err = (sdi & ctrl[`CTRL_RATE3G] & ~ctrl[`CTRL_DOUBLE])
		| (ctrl[`CTRL_MODE_HI:`CTRL_MODE_LO] == 2'b10)
		| (~detlat & ctrl[`CTRL_ENC])
		| (conv & ctrl[`CTRL_DOUBLE]);

	// Parallel clock stays phase-locked to the reference only with feedback on;
	// the reference must then run at the parallel clock rate
	assign PLL_FB_EN = detlat;

	// ****************************************
	// Oversampling phase
	// ****************************************
	logic [2:0] os_cnt;
	logic       bit_step;
	logic       rx_sample;

	always_ff @(posedge SYS_CLK or negedge RST_B) begin
		if (!RST_B) begin
			os_cnt <= 3'h0;
		end else if (!conv || os_cnt == `OS_LAST) begin
			os_cnt <= 3'h0;
		end else begin
			os_cnt <= os_cnt + 3'h1;
		end
	end

	assign bit_step  = !conv || os_cnt == `OS_LAST;
	assign rx_sample = rx_en & (!conv || os_cnt == `OS_MID);

	// ****************************************
	// Transmit phase compensation
	// ****************************************
	logic  tf_in_ready;
	logic  tf_out_valid;
	word_t tf_out_data;
	logic  tpc_v;
	word_t tpc_d;
	logic  src_v;
	word_t src_d;
	logic  take;

	serdes_fifo #(
		.W (`WORD_W),
		.D (`FIFO_DEPTH)
	) u_tx_fifo (
		.clk       (SYS_CLK),
		.rst_b     (RST_B),
		.in_valid  (TX_VALID & tx_en & ~detlat),
		.in_ready  (tf_in_ready),
		.in_data   (TX_DATA),
		.out_valid (tf_out_valid),
		.out_ready (take & ~detlat),
		.out_data  (tf_out_data)
	);

	assign TX_READY = tx_en & (detlat ? (~tpc_v | take) : tf_in_ready);

	// Single register stage: a word taken at one edge is at the serializer at the next
	always_ff @(posedge SYS_CLK or negedge RST_B) begin
		if (!RST_B) begin
			tpc_v <= 1'b0;
			tpc_d <= '0;
		end else if (detlat && TX_VALID && TX_READY) begin
			tpc_v <= 1'b1;
			tpc_d <= TX_DATA;
		end else if (take || !detlat) begin
			tpc_v <= 1'b0;
		end
	end

	assign src_v = detlat ? tpc_v : tf_out_valid;
	assign src_d = detlat ? tpc_d : tf_out_data;

	// ****************************************
	// Byte serializer and serializer
	// ****************************************
	logic       ser_busy;
	logic [4:0] ser_cnt;
	word_t      ser_sh;
	logic       ser_last;

	assign ser_last = ser_cnt == 5'(tot - 5'h1);
	assign take     = tx_en & src_v & bit_step & (~ser_busy | ser_last);

	// Words go out raw, low bit first; a 20-bit word is two 10-bit halves
	always_ff @(posedge SYS_CLK or negedge RST_B) begin
		if (!RST_B) begin
			ser_busy <= 1'b0;
			ser_cnt  <= 5'h00;
			ser_sh   <= '0;
		end else if (bit_step) begin
			if (take) begin
				ser_busy <= 1'b1;
				ser_cnt  <= 5'h00;
				ser_sh   <= src_d;
			end else if (ser_busy && ser_last) begin
				ser_busy <= 1'b0;
				ser_cnt  <= 5'h00;
				ser_sh   <= '0;
			end else if (ser_busy) begin
				ser_cnt <= ser_cnt + 5'h01;
				ser_sh  <= ser_sh >> 1;
			end
		end
	end

	assign TX_SER = ser_sh[0];

	// ****************************************
	// Deserializer with bit-slip aligner
	// ****************************************
	logic       slip_q;
	logic       slip_pend;
	logic [4:0] rx_cnt;
	word_t      rx_sh;
	word_t      next_sh;
	logic       word_v;
	word_t      word_d;

	// The aligner only drops a bit on a slip edge, so a low request keeps the stream intact
	always_ff @(posedge SYS_CLK or negedge RST_B) begin
		if (!RST_B) begin
			slip_q    <= 1'b0;
			slip_pend <= 1'b0;
			slip_cnt  <= 4'h0;
		end else begin
			slip_q <= RX_SLIP;
			if (RX_SLIP && !slip_q) begin
				slip_pend <= 1'b1;
			end else if (rx_sample && slip_pend) begin
				slip_pend <= 1'b0;
			end
			if (rx_sample && slip_pend) begin
				slip_cnt <= slip_cnt + 4'h1;
			end
		end
	end

	always_comb begin
		next_sh         = rx_sh;
		next_sh[rx_cnt] = RX_SER;
	end

	always_ff @(posedge SYS_CLK or negedge RST_B) begin
		if (!RST_B) begin
			rx_cnt <= 5'h00;
			rx_sh  <= '0;
			word_v <= 1'b0;
			word_d <= '0;
		end else begin
			word_v <= 1'b0;
			if (rx_sample && !slip_pend) begin
				if (rx_cnt == 5'(tot - 5'h1)) begin
					rx_cnt <= 5'h00;
					rx_sh  <= '0;
					word_v <= 1'b1;
					word_d <= next_sh;
				end else begin
					rx_cnt <= rx_cnt + 5'h01;
					rx_sh  <= next_sh;
				end
			end
		end
	end

	// ****************************************
	// Receive phase compensation
	// ****************************************
	logic  rf_in_ready;
	logic  rf_out_valid;
	word_t rf_out_data;
	logic  rpc_v;
	word_t rpc_d;
	logic  lost;

	serdes_fifo #(
		.W (`WORD_W),
		.D (`FIFO_DEPTH)
	) u_rx_fifo (
		.clk       (SYS_CLK),
		.rst_b     (RST_B),
		.in_valid  (word_v & ~detlat),
		.in_ready  (rf_in_ready),
		.in_data   (word_d),
		.out_valid (rf_out_valid),
		.out_ready (RX_READY & ~detlat),
		.out_data  (rf_out_data)
	);

	always_ff @(posedge SYS_CLK or negedge RST_B) begin
		if (!RST_B) begin
			rpc_v <= 1'b0;
			rpc_d <= '0;
		end else if (detlat && word_v && (!rpc_v || RX_READY)) begin
			// A stalled word stays put; the newcomer is the one lost
			rpc_v <= 1'b1;
			rpc_d <= word_d;
		end else if (RX_READY || !detlat) begin
			rpc_v <= 1'b0;
		end
	end

	assign RX_VALID = detlat ? rpc_v : rf_out_valid;
	assign RX_DATA  = detlat ? rpc_d : rf_out_data;

	// The line cannot be stalled, so a word with nowhere to go is flagged
	assign lost = word_v & (detlat ? (rpc_v & ~RX_READY) : ~rf_in_ready);

	always_ff @(posedge SYS_CLK or negedge RST_B) begin
		if (!RST_B) begin
			overrun  <= 1'b0;
			rx_words <= 16'h0000;
		end else begin
			if (lost) begin
				overrun <= 1'b1;
			end else if (clr_overrun) begin
				overrun <= 1'b0;
			end
			if (word_v) begin
				rx_words <= rx_words + 16'h0001;
			end
		end
	end
endmodule
`default_nettype wire

// ===== verification/serdes_dl_monitor.sv
// Port-level assertions of the channel datapath
`timescale 1ns/100ps
`default_nettype none
module serdes_dl_monitor (
	// Clock and reset
	input  wire logic                 SYS_CLK,
	input  wire logic                 RST_B,
	// Register bus
	input  wire logic                 HSEL,
	input  wire logic [1:0]           HTRANS,
	input  wire logic                 HWRITE,
	input  wire logic                 HREADY,
	input  wire logic [31:0]          HRDATA,
	input  wire logic                 HREADYOUT,
	input  wire logic                 HRESP,
	// Receive side and controls
	input  wire serdes_dl_pkg::word_t RX_DATA,
	input  wire logic                 RX_VALID,
	input  wire logic                 RX_READY,
	input  wire logic                 PLL_FB_EN,
	input  wire logic                 ENC_EN
);
	import serdes_dl_pkg::*;
	logic wr_dp;
	logic rd_ap;
	default clocking @(posedge SYS_CLK); endclocking
	default disable iff (!RST_B);
	assign rd_ap = HSEL && HREADY && HTRANS[1] && !HWRITE;
	// Controls may only move after a write data phase
	always_ff @(posedge SYS_CLK or negedge RST_B) begin
		if (!RST_B) begin
			wr_dp <= 1'h0;
		end else begin
			wr_dp <= HSEL && HREADY && HTRANS[1] && HWRITE;
		end
	end
	a_resp_okay: assert property (!HRESP)
		else $error("bus response not okay");
	a_bus_ready: assert property (HREADYOUT)
		else $error("bus wait state seen");
	a_enc_needs_fb: assert property (ENC_EN |-> PLL_FB_EN)
		else $error("coder on outside fixed latency");
	a_fb_after_write: assert property ($changed(PLL_FB_EN) |-> $past(wr_dp))
		else $error("feedback enable moved without write");
	a_enc_after_write: assert property ($changed(ENC_EN) |-> $past(wr_dp))
		else $error("coder enable moved without write");
	a_rx_word_held: assert property (RX_VALID && !RX_READY |=> RX_VALID && $stable(RX_DATA))
		else $error("received word dropped while stalled");
	a_rx_valid_drop: assert property ($fell(RX_VALID) |-> $past(RX_READY))
		else $error("receive valid fell without ready");
	a_rdata_hold: assert property ($changed(HRDATA) |-> $past(rd_ap))
		else $error("read data moved without read");
endmodule
bind serdes_sdi_detlat_datapath serdes_dl_monitor serdes_dl_monitor_inst (
	.SYS_CLK(SYS_CLK), .RST_B(RST_B), .HSEL(HSEL), .HTRANS(HTRANS), .HWRITE(HWRITE),
	.HREADY(HREADY), .HRDATA(HRDATA), .HREADYOUT(HREADYOUT), .HRESP(HRESP),
	.RX_DATA(RX_DATA), .RX_VALID(RX_VALID), .RX_READY(RX_READY),
	.PLL_FB_EN(PLL_FB_EN), .ENC_EN(ENC_EN)
);
`default_nettype wire

// ===== verification/serdes_line_partner.sv
// Remote serial transmitter feeding the receive line
`timescale 1ns/100ps
`default_nettype none
module serdes_line_partner (
	// Clock and reset
	input  wire logic clk,
	input  wire logic rst_b,
	// Line
	output logic      ser_out
);
	logic [3:0] bit_i;
	logic [9:0] k;
	logic [9:0] word;
	// Words step by 10'h03b from 10'h155, one word per ten bits, sent LSB first
	assign word = 10'h155 + 10'h03b * k;
	assign ser_out = word[bit_i];
	always_ff @(posedge clk or negedge rst_b) begin
		if (!rst_b) begin
			bit_i <= 4'h0;
			k <= 10'h000;
		end else if (bit_i == 4'h9) begin
			bit_i <= 4'h0;
			k <= k + 10'h001;
		end else begin
			bit_i <= bit_i + 4'h1;
		end
	end
endmodule
`default_nettype wire

// ===== verification/serdes_sdi_detlat_datapath_bench.sv
// Self-checking bench of the channel datapath
`timescale 1ns/100ps
`default_nettype none
`define CHK(a, b) begin checks_done++; if ((a) !== (b)) begin fail_count++; \
	$display("CHECK FAILED t=%0t got=%h exp=%h", $time, (a), (b)); end end
module serdes_sdi_detlat_datapath_bench;
	import serdes_dl_pkg::*;
	logic        sys_clk = 0, rst_b = 0, hsel = 0, hwrite = 0, tx_valid = 0, rx_ready = 1;
	logic [31:0] haddr = 0, hwdata = 0, hrdata;
	logic [1:0]  htrans = 0;
	logic        hreadyout, hresp, tx_ready, rx_valid, tx_ser, rx_ser, pll_fb_en, enc_en;
	word_t       tx_data = 0, rx_data;
	logic        rx_chk = 1, rx_dw = 0;
	logic [15:0] rx_k = 0;
	int          fail_count = 0, checks_done = 0, refused;
	logic [31:0] dl_cfg[4] = '{32'h21, 32'h29, 32'h25, 32'h2d};
	int          dl_nb[4] = '{10, 8, 20, 16};
	always #2 sys_clk = ~sys_clk;
	serdes_sdi_detlat_datapath serdes_sdi_detlat_datapath_inst (
		.SYS_CLK(sys_clk), .RST_B(rst_b), .HSEL(hsel), .HADDR(haddr), .HTRANS(htrans),
		.HWRITE(hwrite), .HSIZE(3'h2), .HWDATA(hwdata), .HREADY(hreadyout),
		.HRDATA(hrdata), .HREADYOUT(hreadyout), .HRESP(hresp), .TX_DATA(tx_data),
		.TX_VALID(tx_valid), .TX_READY(tx_ready), .RX_DATA(rx_data), .RX_VALID(rx_valid),
		.RX_READY(rx_ready), .RX_SLIP(1'h0), .TX_SER(tx_ser), .RX_SER(rx_ser),
		.PLL_FB_EN(pll_fb_en), .ENC_EN(enc_en));
	serdes_line_partner serdes_line_partner_inst (.clk(sys_clk), .rst_b(rst_b), .ser_out(rx_ser));
	// ****
	// Bus cycles and transfers
	// ****
	task automatic bus(input logic wr, input logic [31:0] a, d, output logic [31:0] q);
		hsel <= 1;
		htrans <= 2'h2;
		haddr <= a;
		hwrite <= wr;
		@(posedge sys_clk);
		while (!hreadyout) @(posedge sys_clk);
		htrans <= 2'h0;
		hsel <= 0;
		hwdata <= d;
		@(posedge sys_clk);
		while (!hreadyout) @(posedge sys_clk);
		q = hrdata;
	endtask
	task automatic rd(input logic [31:0] a, m, e);
		logic [31:0] q;
		bus(0, a, 0, q);
		`CHK(q & m, e)
	endtask
	task automatic wr(input logic [31:0] a, d);
		logic [31:0] q;
		bus(1, a, d, q);
	endtask
	// Offers n words back to back and follows every bit on the line
	task automatic tx_seq(input int n, nb, rep);
		logic taken;
		word_t w[8];
		taken = 0;
		refused = 0;
		for (int k = 0; k < n; k++) w[k] = 20'h5a3c6 + 20'h01b39 * 20'(k);
		fork
			begin
				for (int k = 0; k < n; k++) begin
					tx_data <= w[k];
					tx_valid <= 1;
					do begin @(negedge sys_clk); refused += !tx_ready; end while (!tx_ready);
					@(posedge sys_clk);
					taken = 1;
				end
				tx_valid <= 0;
			end
			begin
				wait (taken);
				// Oversampling restarts at the mode write, so the first bit waits a slot
				if (rep > 1) repeat (rep - 2) @(posedge sys_clk);
				for (int i = 0; i < n * nb * rep; i++) begin
					@(posedge sys_clk);
					#1;
					if (i % rep == rep / 2) `CHK(tx_ser, w[i / (nb * rep)][(i / rep) % nb])
				end
			end
		join
		@(posedge sys_clk);
	endtask
	task automatic summarize();
		$display("checks %0d failures %0d", checks_done, fail_count);
		if (fail_count == 0 && checks_done > 0) $display("All tests passed");
		else $display("Some tests failed");
		$finish;
	endtask
	always @(negedge sys_clk) begin
		if (rx_chk && rx_valid && rx_ready) begin
			`CHK(rx_data[9:0], 10'h155 + 10'h03b * rx_k[9:0])
			if (rx_dw) `CHK(rx_data[19:10], 10'h155 + 10'h03b * (rx_k[9:0] + 10'h001))
			rx_k += rx_dw ? 16'h0002 : 16'h0001;
		end
	end
	initial begin
		#100000;
		fail_count++;
		summarize();
	end
	initial begin
		repeat (2) @(posedge sys_clk);
		rst_b <= 1;
		rd(32'h0, 32'h7f, 32'h60);
		rd(32'h10, 32'hffffffff, 32'h0);
		`CHK(pll_fb_en, 1'h0)
		repeat (100) @(posedge sys_clk);
		wr(32'h0, 32'h64);
		repeat (4) @(posedge sys_clk);
		rx_dw = 1;
		repeat (200) @(posedge sys_clk);
		rx_chk = 0;
		`CHK(rx_k > 15, 1'h1)
		wr(32'h0, 32'h60);
		rx_ready <= 0;
		repeat (80) @(posedge sys_clk);
		rd(32'h4, 32'h2, 32'h2);
		rd(32'h4, 32'hf0, 32'h0);
		rx_ready <= 1;
		repeat (20) @(posedge sys_clk);
		wr(32'h4, 32'h2);
		rd(32'h4, 32'h2, 32'h0);
		tx_seq(6, 10, 1);
		`CHK(refused > 0, 1'h1)
		wr(32'h0, 32'h24);
		tx_seq(2, 20, 1);
		wr(32'h0, 32'h30);
		rd(32'h4, 32'h1, 32'h1);
		wr(32'h0, 32'h34);
		rd(32'h4, 32'h1, 32'h0);
		foreach (dl_cfg[j]) begin
			wr(32'h0, dl_cfg[j]);
			rd(32'h4, 32'h4, 32'h4);
			`CHK(pll_fb_en, 1'h1)
			`CHK(enc_en, dl_cfg[j][3])
			tx_seq(1, dl_nb[j], 1);
		end
		wr(32'h0, 32'h23);
		tx_seq(1, 10, 5);
		`CHK(pll_fb_en, 1'h0)
		summarize();
	end
endmodule
`default_nettype wire
